// ==== src/acfs_pkg.sv ====
// Purpose: Shared constants and carriers for the converter result monitor.
// Assumes: One 32-bit word per register on a plain strobe port.
// Notes: Threshold, mode, data and channel 0 offsets are local choices.
package acfs_pkg;
  // Register offsets.
  localparam logic [7:0] OFF_CMP0_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMP1_CTRL = 8'h04;
  localparam logic [7:0] OFF_FIFO_STAT = 8'h08;
  localparam logic [7:0] OFF_CMP0_THR = 8'h0c;
  localparam logic [7:0] OFF_CMP1_THR = 8'h10;
  localparam logic [7:0] OFF_FIFO_DATA = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  localparam logic [7:0] OFF_CH0_DATA = 8'h1c;
  // Comparator control fields.
  localparam int CMP_EN_BIT = 7;
  localparam int CMP_IE_BIT = 6;
  localparam int CMP_FLAG_BIT = 5;
  localparam int COND_MSB = 4;
  localparam int COND_LSB = 0;
  localparam int COND_W = 5;
  localparam int CMP_ID_LSB = 8;
  localparam int CVD_LSB = 16;
  localparam logic [4:0] COND_BTWN = 5'h10;
  localparam logic [4:0] COND_LOLO = 5'h01;
  localparam int CMP0_ID_W = 6;
  localparam int CMP1_ID_W = 5;
  localparam logic [5:0] CMP0_ID_MAX = 6'h2c;
  localparam logic [5:0] NORMAL_ID_MAX = 6'h1f;
  // Threshold word fields.
  localparam int THR_HI_LSB = 16;
  localparam int THR_LO_LSB = 0;
  // Result FIFO status fields.
  localparam int FEN_BIT = 31;
  localparam int CH0EN_BIT = 24;
  localparam int FIE_BIT = 23;
  localparam int FIFO_READY_FLAG_BIT = 22;
  localparam int FOVF_BIT = 21;
  localparam int FIFO_ENTRY_COUNT_LSB = 8;
  localparam int FIFO_SIGN_BIT_BIT = 7;
  localparam int FCH_LSB = 0;
  localparam logic [2:0] FIFO_CH_ID = 3'h0;
  localparam logic [5:0] CH0_INPUT = 6'h00;
  // Mode register fields.
  localparam int MODE_CVD_BIT = 0;
  localparam int MODE_FRACTIONAL_FORMAT_SELECT_BIT = 1;
  // Reset values.
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } acfs_bus_s;

  typedef struct packed {
    logic valid;
    logic [5:0] id;
    logic [15:0] pos;
    logic [15:0] neg;
  } acfs_sample_s;
endpackage : acfs_pkg

// ==== src/acfs_cond_eval.sv ====
// Purpose: Evaluates the five threshold conditions of one comparator.
// Assumes: Value and thresholds arrive already extended to 17 signed bits.
// Notes: HI_INCL picks whether the between window includes the high limit.
module acfs_cond_eval
  import acfs_pkg::*;
#(
  parameter bit HI_INCL = 1'b1
) (
  // Operands.
  input wire logic signed [16:0] value,
  input wire logic signed [16:0] low,
  input wire logic signed [16:0] high,
  // Enabled conditions.
  input wire logic [COND_W-1:0] cond,
  // Result.
  output logic hit
);
  logic btwn;

  always_comb begin
    btwn = (low <= value) && (HI_INCL ? (value <= high) : (value < high));
    // Any enabled condition that holds makes the output true.
    hit = (cond[4] && btwn)
      || (cond[3] && (high <= value))
      || (cond[2] && (value < high))
      || (cond[1] && (low <= value))
      || (cond[0] && (value < low));
  end
endmodule : acfs_cond_eval

// ==== src/acfs_top.sv ====
// Purpose: Digital comparators and channel 0 result FIFO of a converter.
// Assumes: Results arrive on clk_sys as one-cycle valid samples.
// Notes: Reads return data one cycle after the read strobe.
//
// The strobed register port and the register addresses were decided locally.
module acfs_top
  import acfs_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Register port.
  input wire acfs_bus_s bus,
  output logic [31:0] rdata,
  // Converter core results.
  input wire acfs_sample_s sample,
  // Status outputs.
  output logic cmp0_irq,
  output logic cmp1_irq,
  output logic fifo_irq,
  output logic [15:0] ch0_out
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [7:0] CNT_FULL = 8'(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two from 2 to 128");
  end

  function automatic logic [15:0] cmp_word(
    input logic en,
    input logic ie,
    input logic flag,
    input logic [COND_W-1:0] cond,
    input logic [5:0] id
  );
    logic [15:0] w;
    w = 16'h0000;
    w[CMP_EN_BIT] = en;
    w[CMP_IE_BIT] = ie;
    w[CMP_FLAG_BIT] = flag;
    w[COND_MSB:COND_LSB] = cond;
    w[CMP_ID_LSB +: CMP0_ID_W] = id;
    return w;
  endfunction : cmp_word

  // Software state.
  logic cmp0_en, cmp0_ie, cmp1_en, cmp1_ie;
  logic [COND_W-1:0] cmp0_cond, cmp1_cond;
  logic [15:0] hi0, lo0, hi1, lo1;
  logic cvd_mode, fractional_format_select_sel, fifo_enable, ch0en, fie;
  // Hardware state.
  logic cmp0_flag, cmp1_flag, fovf;
  logic [CMP0_ID_W-1:0] cmp0_id;
  logic [CMP1_ID_W-1:0] cmp1_id;
  logic [15:0] cvd_cap;
  logic [15:0] mem [FIFO_DEPTH];
  logic [PW-1:0] wptr, rptr;
  logic [7:0] fifo_entry_count;

  // Decoded strobes and sample paths.
  logic wr_cmp0, wr_cmp1, rd_cmp0, rd_stat, pop, push, full, ready;
  logic [15:0] diff;
  logic signed [16:0] val0, lo0_x, hi0_x, val1;
  logic acc0, acc1, hit0, hit1, ev0, ev1;
  logic [31:0] next_rdata;

  assign wr_cmp0 = bus.wr && bus.addr == OFF_CMP0_CTRL;
  assign wr_cmp1 = bus.wr && bus.addr == OFF_CMP1_CTRL;
  assign rd_cmp0 = bus.rd && bus.addr == OFF_CMP0_CTRL;
  assign rd_stat = bus.rd && bus.addr == OFF_FIFO_STAT;

  // In divider mode comparator 0 compares the signed difference against signed limits.
  assign diff = sample.pos - sample.neg;
  assign val0 = cvd_mode ? {diff[15], diff} : {1'b0, sample.pos};
  assign lo0_x = cvd_mode ? {lo0[15], lo0} : {1'b0, lo0};
  assign hi0_x = cvd_mode ? {hi0[15], hi0} : {1'b0, hi0};
  assign val1 = {1'b0, sample.pos};
  assign acc0 = sample.valid &&
    (sample.id <= (cvd_mode ? CMP0_ID_MAX : NORMAL_ID_MAX));
  assign acc1 = sample.valid && sample.id <= NORMAL_ID_MAX;
  assign ev0 = cmp0_en && acc0 && hit0;
  assign ev1 = cmp1_en && acc1 && hit1;

  acfs_cond_eval #(.HI_INCL(1'b1)) u_cmp0 (
    .value(val0),
    .low(lo0_x),
    .high(hi0_x),
    .cond(cmp0_cond),
    .hit(hit0)
  );

  acfs_cond_eval #(.HI_INCL(1'b0)) u_cmp1 (
    .value(val1),
    .low({1'b0, lo1}),
    .high({1'b0, hi1}),
    .cond(cmp1_cond),
    .hit(hit1)
  );

  // Control registers written by software.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {cmp0_en, cmp0_ie, cmp0_cond} <= CTRL_RST[6:0];
      {cmp1_en, cmp1_ie, cmp1_cond} <= CTRL_RST[6:0];
    end else begin
      if (wr_cmp0) begin
        cmp0_en <= bus.wdata[CMP_EN_BIT];
        cmp0_ie <= bus.wdata[CMP_IE_BIT];
        cmp0_cond <= bus.wdata[COND_MSB:COND_LSB];
      end
      if (wr_cmp1) begin
        cmp1_en <= bus.wdata[CMP_EN_BIT];
        cmp1_ie <= bus.wdata[CMP_IE_BIT];
        cmp1_cond <= bus.wdata[COND_MSB:COND_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {hi0, lo0, hi1, lo1} <= {THR_RST, THR_RST, THR_RST, THR_RST};
      {cvd_mode, fractional_format_select_sel} <= 2'b00;
      {fifo_enable, ch0en, fie} <= 3'b000;
    end else if (bus.wr) begin
      case (bus.addr)
        OFF_CMP0_THR: begin
          hi0 <= bus.wdata[THR_HI_LSB +: 16];
          lo0 <= bus.wdata[THR_LO_LSB +: 16];
        end
        OFF_CMP1_THR: begin
          hi1 <= bus.wdata[THR_HI_LSB +: 16];
          lo1 <= bus.wdata[THR_LO_LSB +: 16];
        end
        OFF_MODE: begin
          cvd_mode <= bus.wdata[MODE_CVD_BIT];
          fractional_format_select_sel <= bus.wdata[MODE_FRACTIONAL_FORMAT_SELECT_BIT];
        end
        OFF_FIFO_STAT: begin
          fifo_enable <= bus.wdata[FEN_BIT];
          ch0en <= bus.wdata[CH0EN_BIT];
          fie <= bus.wdata[FIE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Event flags: an event wins over a same-cycle read clear.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmp0_flag <= 1'b0;
      cmp1_flag <= 1'b0;
    end else begin
      if (!cmp0_en) begin
        cmp0_flag <= 1'b0;
      end else if (ev0) begin
        cmp0_flag <= 1'b1;
      end else if (rd_cmp0) begin
        cmp0_flag <= 1'b0;
      end
      if (!cmp1_en) begin
        cmp1_flag <= 1'b0;
      end else if (ev1) begin
        cmp1_flag <= 1'b1;
      end else if (rd_cmp0) begin
        cmp1_flag <= 1'b0;
      end
    end
  end

  // Input ids follow each event; the divider capture follows comparator 0 events with cmp0_ie set in divider mode.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmp0_id <= '0;
      cmp1_id <= '0;
      cvd_cap <= 16'h0000;
    end else begin
      if (ev0) begin
        cmp0_id <= sample.id;
      end
      if (ev1) begin
        cmp1_id <= sample.id[CMP1_ID_W-1:0];
      end
      if (ev0 && cmp0_ie && cvd_mode) begin
        cvd_cap <= diff;
      end
    end
  end

  assign cmp0_irq = cmp0_flag && cmp0_ie;
  assign cmp1_irq = cmp1_flag && cmp1_ie;

  // Channel 0 output register keeps every channel 0 result.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch0_out <= 16'h0000;
    end else if (sample.valid && sample.id == CH0_INPUT) begin
      ch0_out <= sample.pos;
    end
  end

  // Result FIFO; a full write drops the oldest entry.
  assign full = fifo_entry_count == CNT_FULL;
  assign push = sample.valid && sample.id == CH0_INPUT
    && fifo_enable && ch0en;
  assign pop = bus.rd && bus.addr == OFF_FIFO_DATA && fifo_entry_count != 8'h00;
  assign ready = fifo_entry_count != 8'h00;
  assign fifo_irq = fie && ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= sample.pos;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr <= '0;
      rptr <= '0;
      fifo_entry_count <= 8'h00;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop || (push && full)) begin
        rptr <= rptr + 1'b1;
      end
      if (push && !full && !pop) begin
        fifo_entry_count <= fifo_entry_count + 8'h01;
      end else if (pop && !push) begin
        fifo_entry_count <= fifo_entry_count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fovf <= 1'b0;
    end else if (push && full) begin
      fovf <= 1'b1;
    end else if (rd_stat) begin
      fovf <= 1'b0;
    end
  end

  // Read data, registered one cycle after the strobe.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (bus.addr)
      OFF_CMP0_CTRL: begin
        next_rdata[15:0] = cmp_word(cmp0_en, cmp0_ie, cmp0_flag,
          cmp0_cond, cmp0_id);
        next_rdata[CVD_LSB +: 16] = cvd_cap;
      end
      OFF_CMP1_CTRL: begin
        next_rdata[15:0] = cmp_word(cmp1_en, cmp1_ie, cmp1_flag,
          cmp1_cond, {1'b0, cmp1_id});
      end
      OFF_FIFO_STAT: begin
        next_rdata[FEN_BIT] = fifo_enable;
        next_rdata[CH0EN_BIT] = ch0en;
        next_rdata[FIE_BIT] = fie;
        next_rdata[FIFO_READY_FLAG_BIT] = ready;
        next_rdata[FOVF_BIT] = fovf;
        next_rdata[FIFO_ENTRY_COUNT_LSB +: 8] = fifo_entry_count;
        next_rdata[FIFO_SIGN_BIT_BIT] = ready && mem[rptr][15];
        next_rdata[FCH_LSB +: 3] = FIFO_CH_ID;
      end
      OFF_CMP0_THR: begin
        next_rdata = {hi0, lo0};
      end
      OFF_CMP1_THR: begin
        next_rdata = {hi1, lo1};
      end
      OFF_FIFO_DATA: begin
        if (ready) begin
          next_rdata[15:0] = mem[rptr];
        end
      end
      OFF_MODE: begin
        next_rdata[MODE_CVD_BIT] = cvd_mode;
        next_rdata[MODE_FRACTIONAL_FORMAT_SELECT_BIT] = fractional_format_select_sel;
      end
      OFF_CH0_DATA: begin
        next_rdata[15:0] = ch0_out;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= RDATA_RST;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= RDATA_RST;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_CVD_CAPTURE: assert property (
    ev0 && cmp0_ie && cvd_mode |=> cvd_cap == $past(diff))
    else $error("divider capture missed");
  AST_ID0_RANGE: assert property (
    cmp0_id <= CMP0_ID_MAX)
    else $error("comparator 0 id out of range");
  AST_NORMAL_LIMIT: assert property (
    !cvd_mode && sample.valid && sample.id > NORMAL_ID_MAX && !cmp0_flag
    |=> !cmp0_flag)
    else $error("comparator 0 took a high input");
  AST_CMP1_LIMIT: assert property (
    sample.valid && sample.id > NORMAL_ID_MAX && !cmp1_flag |=> !cmp1_flag)
    else $error("comparator 1 took a high input");
  AST_DISABLE_CLEARS: assert property (
    !cmp0_en ##1 !cmp0_en |-> !cmp0_flag)
    else $error("disabled comparator kept its flag");
  AST_IRQ_FOLLOWS: assert property (
    ev1 && cmp1_ie |=> cmp1_irq)
    else $error("comparator 1 interrupt missing");
  AST_READ_CLEARS: assert property (
    rd_cmp0 && !ev0 && !ev1 |=> !cmp0_flag && !cmp1_flag)
    else $error("id read left a flag set");
  AST_LOLO: assert property (
    cmp0_en && acc0 && cmp0_cond == COND_LOLO && val0 < lo0_x |=> cmp0_flag)
    else $error("low-low event missed");
  AST_BTWN_EXCL: assert property (
    cmp1_en && acc1 && cmp1_cond == COND_BTWN && val1 == {1'b0, hi1}
    && !cmp1_flag |=> !cmp1_flag)
    else $error("comparator 1 between included high");
  AST_NO_STORE: assert property (
    !fifo_enable && fifo_entry_count == 8'h00 |=> fifo_entry_count == 8'h00)
    else $error("disabled FIFO stored data");
  AST_COUNT_UP: assert property (
    push && !pop && !full |=> fifo_entry_count == $past(fifo_entry_count) + 8'h01)
    else $error("FIFO count did not rise");
  AST_OVERFLOW: assert property (
    push && full |=> fovf && fifo_entry_count == CNT_FULL)
    else $error("overflow not flagged");
endmodule : acfs_top

// ==== tb/acfs_src_model.sv ====
// Purpose: Converter core model that hands results to the monitor.
// Assumes: One result per call, one cycle of valid, sent after an edge.
// Notes: Between results the fields carry the inverse of the last ones.
module acfs_src_model
  import acfs_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Result stream.
  output acfs_sample_s sample
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sample = '0;
  end

  task automatic send(input logic [5:0] id, input logic [15:0] pos,
                      input logic [15:0] neg);
    @(posedge clk_sys);
    sample <= '{1'b1, id, pos, neg};
    @(posedge clk_sys);
    sample <= '{1'b0, ~id, ~pos, ~neg};
  endtask : send
endmodule : acfs_src_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the converter result monitor.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: A four-entry FIFO keeps the overflow case short.
module testbench
  import acfs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic clk_sys;
  logic srst;
  acfs_bus_s bus;
  logic [31:0] rdata;
  acfs_sample_s sample;
  logic cmp0_irq;
  logic cmp1_irq;
  logic fifo_irq;
  logic [15:0] ch0_out;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  acfs_top #(.FIFO_DEPTH(DEPTH)) i_acfs_top (
    .clk_sys(clk_sys), .srst(srst), .bus(bus), .rdata(rdata),
    .sample(sample), .cmp0_irq(cmp0_irq), .cmp1_irq(cmp1_irq),
    .fifo_irq(fifo_irq), .ch0_out(ch0_out));
  acfs_src_model i_acfs_src_model (.clk_sys(clk_sys), .sample(sample));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk_sys);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  // Any enabled condition that holds fires; none enabled never fires.
  function automatic logic hit(input int k, input logic [4:0] c,
                               input logic [15:0] v);
    hit = (c[4] && 16'h0020 <= v && (k == 0 ? v <= 16'h0040 : v < 16'h0040))
      || (c[3] && 16'h0040 <= v) || (c[2] && v < 16'h0040)
      || (c[1] && 16'h0020 <= v) || (c[0] && v < 16'h0020);
  endfunction : hit

  function automatic logic irq(input int k);
    irq = (k == 0) ? cmp0_irq : cmp1_irq;
  endfunction : irq

  function automatic logic [31:0] st(input logic r, input logic o,
                                     input logic [7:0] n, input logic s);
    st = 32'h8180_0000 | {9'h0, r, o, 5'h0, n, s, 7'h0};
  endfunction : st

  task automatic t_reset();
    logic [31:0] d;
    for (int a = 0; a <= 32; a += 4) begin
      rd(a[7:0], d);
      chk("reset value", 32'h0, d);
    end
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    wr(OFF_CMP1_CTRL, 32'hffff_ffff);
    rd(OFF_CMP1_CTRL, d);
    chk("cmp1 access", 32'h0000_00df, d);
    wr(OFF_CMP1_CTRL, 32'h0);
    wr(OFF_CMP1_THR, 32'h1234_5678);
    rd(OFF_CMP1_THR, d);
    chk("threshold", 32'h1234_5678, d);
    wr(OFF_MODE, 32'hffff_ffff);
    rd(OFF_MODE, d);
    chk("mode", 32'h0000_0003, d);
    wr(OFF_MODE, 32'h0);
  endtask : t_reset

  task automatic t_cond(input int k);
    logic [15:0] v[4] = '{16'h001f, 16'h0020, 16'h0040, 16'h0041};
    logic [31:0] d;
    logic [7:0] ctl;
    logic [4:0] cv;
    logic e;
    ctl = (k == 0) ? OFF_CMP0_CTRL : OFF_CMP1_CTRL;
    wr((k == 0) ? OFF_CMP0_THR : OFF_CMP1_THR, 32'h0040_0020);
    for (int c = 0; c < 6; c++) begin
      cv = (c == 5) ? 5'h00 : 5'(1 << c);
      wr(ctl, {24'h0, 3'h4, cv});
      for (int i = 0; i < 4; i++) begin
        i_acfs_src_model.send(6'h13, v[i], 16'h0000);
        rd(ctl, d);
        e = hit(k, cv, v[i]);
        chk("flag", {31'h0, e}, {31'h0, d[5]});
        chk("flag", {31'h0, e}, {31'h0, d[5]});
        chk("flag", {31'h0, e}, {31'h0, d[5]});
        if (e)
          chk("id", 32'h13, {26'h0, d[13:8]});
        rd(OFF_CMP0_CTRL, d);
        rd(ctl, d);
        chk("flag cleared", 32'h0, {31'h0, d[5]});
      end
    end
  endtask : t_cond

  task automatic t_irq(input int k);
    logic [31:0] d;
    logic [7:0] ctl;
    logic [5:0] id;
    ctl = (k == 0) ? OFF_CMP0_CTRL : OFF_CMP1_CTRL;
    id = (k == 0) ? 6'h1f : 6'h1d;
    wr(ctl, 32'h0000_00c1);
    i_acfs_src_model.send(id, 16'h0000, 16'h0000);
    #1 chk("irq set", 32'h1, {31'h0, irq(k)});
    rd(ctl, d);
    chk("top id", {26'h0, id}, {26'h0, d[13:8]});
    rd(OFF_CMP0_CTRL, d);
    i_acfs_src_model.send(6'h20, 16'h0000, 16'h0000);
    #1 chk("id above 31", 32'h0, {31'h0, irq(k)});
    i_acfs_src_model.send(6'h05, 16'h0000, 16'h0000);
    wr(ctl, 32'h0000_0041);
    rd(ctl, d);
    chk("disable clears", 32'h0, {31'h0, d[5]});
    chk("irq off", 32'h0, {31'h0, irq(k)});
    wr(ctl, 32'h0000_0081);
    i_acfs_src_model.send(6'h05, 16'h0000, 16'h0000);
    #1 chk("irq masked", 32'h0, {31'h0, irq(k)});
    rd(ctl, d);
    chk("masked flag", 32'h1, {31'h0, d[5]});
    rd(OFF_CMP0_CTRL, d);
    wr(ctl, 32'h0);
  endtask : t_irq

  task automatic t_cvd();
    logic [31:0] d;
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_CMP0_THR, 32'h0010_fff0);
    wr(OFF_CMP0_CTRL, 32'h0000_00d0);
    i_acfs_src_model.send(6'h28, 16'h0005, 16'h0008);
    rd(OFF_CMP0_CTRL, d);
    chk("signed window", 32'h1, {31'h0, d[5]});
    chk("capture", 32'h0000_fffd, {16'h0, d[31:16]});
    chk("divider id", 32'h28, {26'h0, d[13:8]});
    wr(OFF_CMP0_CTRL, 32'h0);
    wr(OFF_MODE, 32'h0);
  endtask : t_cvd

  task automatic t_fifo();
    logic [15:0] p[5] = '{16'h8001, 16'h0002, 16'h0003, 16'h0004,
                          16'h0005};
    logic [31:0] d;
    wr(OFF_FIFO_STAT, 32'h0100_0000);
    i_acfs_src_model.send(6'h00, 16'h1234, 16'h0000);
    rd(OFF_FIFO_STAT, d);
    chk("fifo off", 32'h0100_0000, d);
    rd(OFF_CH0_DATA, d);
    chk("ch0 reg", 32'h0000_1234, d);
    chk("ch0 out", 32'h0000_1234, {16'h0, ch0_out});
    wr(OFF_FIFO_STAT, 32'h8180_0000);
    for (int i = 0; i < 4; i++)
      i_acfs_src_model.send(6'h00, p[i], 16'h0000);
    rd(OFF_FIFO_STAT, d);
    chk("full", st(1'b1, 1'b0, 8'h4, 1'b1), d);
    chk("fifo irq", 32'h1, {31'h0, fifo_irq});
    i_acfs_src_model.send(6'h01, 16'h7777, 16'h0000);
    i_acfs_src_model.send(6'h00, p[4], 16'h0000);
    rd(OFF_FIFO_STAT, d);
    chk("overflow", st(1'b1, 1'b1, 8'h4, 1'b0), d);
    rd(OFF_FIFO_STAT, d);
    chk("overflow read", st(1'b1, 1'b0, 8'h4, 1'b0), d);
    for (int i = 1; i < 5; i++) begin
      rd(OFF_FIFO_DATA, d);
      chk("fifo data", {16'h0, p[i]}, d);
      rd(OFF_FIFO_STAT, d);
      chk("drain", st(i < 4, 1'b0, 8'(4 - i), 1'b0), d);
    end
    chk("fifo irq off", 32'h0, {31'h0, fifo_irq});
    rd(OFF_FIFO_DATA, d);
    chk("empty pop", 32'h0, d);
  endtask : t_fifo

  initial begin
    srst = 1'b1;
    bus = '0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_cond(0);
    t_cond(1);
    t_irq(0);
    t_irq(1);
    t_cvd();
    t_fifo();
    print_verdict();
  end
endmodule : testbench
